// ===== hdl/ctb_pkg.sv
// shared constants and types for the instruction timing decoder
`default_nettype none
package ctb_pkg;

  // instruction lengths in bytes
  localparam logic [1:0] CTB_LEN_1 = 2'h1;
  localparam logic [1:0] CTB_LEN_2 = 2'h2;
  localparam logic [1:0] CTB_LEN_3 = 2'h3;

  // execution times in core cycles
  localparam logic [2:0] CTB_CYC_1 = 3'h1;
  localparam logic [2:0] CTB_CYC_2 = 3'h2;
  localparam logic [2:0] CTB_CYC_3 = 3'h3;
  localparam logic [2:0] CTB_CYC_4 = 3'h4;
  localparam logic [2:0] CTB_CYC_5 = 3'h5;

  // bit space layout
  localparam int CTB_BIT_RAM_BITS = 128;
  localparam int CTB_BIT_POS_W = 3;
  localparam logic [7:0] CTB_BIT_RAM_BASE = 8'h00;

  typedef enum logic [2:0] {
    SP_NONE, SP_CORE, SP_XDATA, SP_CODE, SP_BIT
  } ctb_space_t;

  typedef enum logic [2:0] {
    MD_IMPLIED, MD_DIRECT, MD_INDIRECT, MD_BANK, MD_IMMED, MD_INDEXED,
    MD_BIT
  } ctb_mode_t;

  typedef enum logic [5:0] {
    OP_MV_A_BANK, OP_MV_A_DIR, OP_MV_A_IND, OP_MV_A_IMM,
    OP_MV_BANK_A, OP_MV_BANK_DIR, OP_MV_BANK_IMM,
    OP_MV_DIR_A, OP_MV_DIR_BANK, OP_MV_DIR_DIR, OP_MV_DIR_IND,
    OP_MV_DIR_IMM, OP_MV_IND_A, OP_MV_IND_DIR, OP_MV_IND_IMM,
    OP_MV_DP_IMM, OP_CT_DP, OP_CT_PROG,
    OP_XD_RD_IND, OP_XD_RD_DP, OP_XD_WR_IND, OP_XD_WR_DP,
    OP_PUSH_DIR, OP_POP_DIR,
    OP_SWP_BANK, OP_SWP_DIR, OP_SWP_IND, OP_SWPD_IND,
    OP_CY_CLR, OP_CY_SET, OP_CY_INV, OP_BIT_CLR, OP_BIT_SET, OP_BIT_INV,
    OP_CY_AND, OP_CY_ANDN, OP_CY_OR, OP_CY_ORN, OP_CY_LD, OP_CY_ST,
    OP_J_CY, OP_J_NCY, OP_J_BIT, OP_J_NBIT, OP_J_BITCLR,
    OP_CALL_ABS, OP_CALL_LONG, OP_SUB_EXIT, OP_INT_EXIT,
    OP_J_ABS, OP_J_LONG, OP_J_SHORT, OP_J_IND, OP_J_AZ, OP_J_ANZ,
    OP_CMP_A_DIR, OP_CMP_A_IMM, OP_CMP_BANK_IMM, OP_CMP_IND_IMM,
    OP_DEC_BANK, OP_DEC_DIR, OP_NOP
  } ctb_op_t;

  typedef struct packed {
    logic [1:0] len;
    logic [2:0] cyc;
    ctb_space_t sp;
    ctb_mode_t md;
  } ctb_ent_t;

endpackage
`default_nettype wire

// ===== hdl/ctb_cycle_counter.sv
// down counter that holds an instruction for its cycle count
`default_nettype none
module ctb_cycle_counter
  import ctb_pkg::*;
#(
  parameter int W = 3
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic active,
  output logic busy,
  output logic last
);

  logic [W-1:0] cnt_q, cnt_d;
  logic act_q, act_d;

  ////////////////////////////////////////////////////////////////////////
  // next count: load n-1, then walk down to zero
  always_comb begin
    cnt_d = cnt_q;
    act_d = act_q;
    if (load) begin
      cnt_d = load_val - W'(1);
      act_d = 1'b1;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end else begin
      act_d = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      act_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      act_q <= act_d;
    end
  end

  // busy blocks the next fetch; last marks the final cycle
  assign active = act_q;
  assign busy = cnt_q != '0;
  assign last = act_q && (cnt_q == '0);

endmodule
`default_nettype wire

// ===== hdl/ctb_decoder.sv
// decode and cycle timing of transfer, bit and branch instructions
// Behaviour
// RULE1: core moves reach any internal RAM or special register by four modes
// RULE2: external data moves only with accumulator, always indirect
// RULE3: code table reads use base pointer plus accumulator, read only
// RULE4: bit space: 128 RAM bits plus bit-addressable special registers
// RULE5: loads into accumulator: 1/1, 2/2, 2/2 and 1/2 bytes/cycles
// RULE6: loads into bank register: 1/1, 2/3, 2/2
// RULE7: stores to direct byte: 2/2, 2/2, 2/3, 3/3, 3/3
// RULE8: stores to indirect RAM: 1/2, 2/3, 2/2
// RULE9: data pointer constant load is 3 bytes, 3 cycles
// RULE10: code table read is 5 cycles via data pointer, 4 via counter
// RULE11: external reads take 4 cycles 8-bit, 3 cycles 16-bit
// RULE12: external writes take 5 cycles 8-bit, 4 cycles 16-bit
// RULE13: push is 2 bytes 3 cycles, pop 2 bytes 2 cycles
// RULE14: swaps: bank 1/2, direct 2/3, indirect 1/3, low digit 1/3
// RULE15: carry ops 1/1; direct bit ops and carry store 2/3
// RULE16: carry load, and/or with bit or complement: 2 bytes 2 cycles
// RULE17: carry jumps 2/3; bit jumps 3/5; test-clear form clears set bit
// RULE18: absolute and short jumps 2/3; long jump, calls, returns 4
// RULE19: indirect jump via accumulator plus data pointer: 1 byte 5 cycles
// RULE20: accumulator zero and nonzero jumps: 2 bytes 4 cycles
// RULE21: compare-jumps 3 bytes; direct and indirect 5, others 4 cycles
// RULE22: decrement-jumps: bank 2/4, direct 3/5
// RULE23: next instruction starts only after the listed count elapses
`default_nettype none
module ctb_decoder
  import ctb_pkg::*;
#(
  parameter logic [7:0] BIT_RAM_BASE = CTB_BIT_RAM_BASE
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic op_valid,
  output logic op_ready,
  input wire ctb_op_t op_code,
  input wire logic [7:0] operand_in,
  input wire logic [2:0] reg_idx_in,
  input wire logic [7:0] ptr_reg_in,
  input wire logic [7:0] acc_in,
  input wire logic [15:0] data_pointer_in,
  input wire logic [15:0] program_counter_in,
  input wire logic carry_in,
  input wire logic [7:0] bit_addr_in,
  input wire logic bit_val_in,
  input wire logic [7:0] cmp_lhs_in,
  input wire logic [7:0] cmp_rhs_in,
  input wire logic [7:0] dec_val_in,
  output logic instr_done,
  output logic [1:0] instr_len_q,
  output logic [2:0] instr_cyc_q,
  output ctb_space_t space_q,
  output ctb_mode_t mode_q,
  output logic [7:0] core_addr_q,
  output logic [15:0] mem_addr_q,
  output logic xd_rd_q,
  output logic xd_wr_q,
  output logic code_rd_q,
  output logic bit_in_sfr_q,
  output logic [2:0] bit_pos_q,
  output logic bit_wr_q,
  output logic bit_wr_val_q,
  output logic carry_wr_q,
  output logic carry_val_q,
  output logic jump_taken_q
);

  logic accept;
  logic busy;
  ctb_ent_t ent;
  logic [15:0] idx_dp, idx_pc;
  logic [7:0] bit_byte;
  logic bit_sfr;

  function automatic ctb_ent_t mk(logic [1:0] l, logic [2:0] c,
                                  ctb_space_t s, ctb_mode_t m);
    ctb_ent_t e;
    e.len = l;
    e.cyc = c;
    e.sp = s;
    e.md = m;
    return e;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // length, cycle count, space and mode of each instruction
  always_comb begin
    ent = mk(CTB_LEN_1, CTB_CYC_1, SP_NONE, MD_IMPLIED);
    case (op_code)
      OP_MV_A_BANK:   ent = mk(CTB_LEN_1, CTB_CYC_1, SP_CORE, MD_BANK); // RULE5
      OP_MV_A_DIR:    ent = mk(CTB_LEN_2, CTB_CYC_2, SP_CORE, MD_DIRECT); // RULE5
      OP_MV_A_IND:    ent = mk(CTB_LEN_1, CTB_CYC_2, SP_CORE, MD_INDIRECT); // RULE5
      OP_MV_A_IMM:    ent = mk(CTB_LEN_2, CTB_CYC_2, SP_CORE, MD_IMMED); // RULE5
      OP_MV_BANK_A:   ent = mk(CTB_LEN_1, CTB_CYC_1, SP_CORE, MD_BANK); // RULE6
      OP_MV_BANK_DIR: ent = mk(CTB_LEN_2, CTB_CYC_3, SP_CORE, MD_DIRECT); // RULE6
      OP_MV_BANK_IMM: ent = mk(CTB_LEN_2, CTB_CYC_2, SP_CORE, MD_BANK); // RULE6
      OP_MV_DIR_A:    ent = mk(CTB_LEN_2, CTB_CYC_2, SP_CORE, MD_DIRECT); // RULE7
      OP_MV_DIR_BANK: ent = mk(CTB_LEN_2, CTB_CYC_2, SP_CORE, MD_DIRECT); // RULE7
      OP_MV_DIR_DIR:  ent = mk(CTB_LEN_3, CTB_CYC_3, SP_CORE, MD_DIRECT); // RULE7
      OP_MV_DIR_IND:  ent = mk(CTB_LEN_2, CTB_CYC_3, SP_CORE, MD_INDIRECT); // RULE7
      OP_MV_DIR_IMM:  ent = mk(CTB_LEN_3, CTB_CYC_3, SP_CORE, MD_DIRECT); // RULE7
      OP_MV_IND_A:    ent = mk(CTB_LEN_1, CTB_CYC_2, SP_CORE, MD_INDIRECT); // RULE8
      OP_MV_IND_DIR:  ent = mk(CTB_LEN_2, CTB_CYC_3, SP_CORE, MD_INDIRECT); // RULE8
      OP_MV_IND_IMM:  ent = mk(CTB_LEN_2, CTB_CYC_2, SP_CORE, MD_INDIRECT); // RULE8
      OP_MV_DP_IMM:   ent = mk(CTB_LEN_3, CTB_CYC_3, SP_NONE, MD_IMMED); // RULE9
      OP_CT_DP:       ent = mk(CTB_LEN_1, CTB_CYC_5, SP_CODE, MD_INDEXED); // RULE10
      OP_CT_PROG:     ent = mk(CTB_LEN_1, CTB_CYC_4, SP_CODE, MD_INDEXED); // RULE10
      OP_XD_RD_IND:   ent = mk(CTB_LEN_1, CTB_CYC_4, SP_XDATA, MD_INDIRECT); // RULE11
      OP_XD_RD_DP:    ent = mk(CTB_LEN_1, CTB_CYC_3, SP_XDATA, MD_INDIRECT); // RULE11
      OP_XD_WR_IND:   ent = mk(CTB_LEN_1, CTB_CYC_5, SP_XDATA, MD_INDIRECT); // RULE12
      OP_XD_WR_DP:    ent = mk(CTB_LEN_1, CTB_CYC_4, SP_XDATA, MD_INDIRECT); // RULE12
      OP_PUSH_DIR:    ent = mk(CTB_LEN_2, CTB_CYC_3, SP_CORE, MD_DIRECT); // RULE13
      OP_POP_DIR:     ent = mk(CTB_LEN_2, CTB_CYC_2, SP_CORE, MD_DIRECT); // RULE13
      OP_SWP_BANK:    ent = mk(CTB_LEN_1, CTB_CYC_2, SP_CORE, MD_BANK); // RULE14
      OP_SWP_DIR:     ent = mk(CTB_LEN_2, CTB_CYC_3, SP_CORE, MD_DIRECT); // RULE14
      OP_SWP_IND,
      OP_SWPD_IND:    ent = mk(CTB_LEN_1, CTB_CYC_3, SP_CORE, MD_INDIRECT); // RULE14
      OP_CY_CLR, OP_CY_SET,
      OP_CY_INV:      ent = mk(CTB_LEN_1, CTB_CYC_1, SP_NONE, MD_IMPLIED); // RULE15
      OP_BIT_CLR, OP_BIT_SET, OP_BIT_INV,
      OP_CY_ST:       ent = mk(CTB_LEN_2, CTB_CYC_3, SP_BIT, MD_BIT); // RULE15
      OP_CY_AND, OP_CY_ANDN, OP_CY_OR, OP_CY_ORN,
      OP_CY_LD:       ent = mk(CTB_LEN_2, CTB_CYC_2, SP_BIT, MD_BIT); // RULE16
      OP_J_CY,
      OP_J_NCY:       ent = mk(CTB_LEN_2, CTB_CYC_3, SP_NONE, MD_IMPLIED); // RULE17
      OP_J_BIT, OP_J_NBIT,
      OP_J_BITCLR:    ent = mk(CTB_LEN_3, CTB_CYC_5, SP_BIT, MD_BIT); // RULE17
      OP_CALL_ABS:    ent = mk(CTB_LEN_2, CTB_CYC_4, SP_NONE, MD_IMPLIED); // RULE18
      OP_CALL_LONG,
      OP_J_LONG:      ent = mk(CTB_LEN_3, CTB_CYC_4, SP_NONE, MD_IMPLIED); // RULE18
      OP_SUB_EXIT,
      OP_INT_EXIT:    ent = mk(CTB_LEN_1, CTB_CYC_4, SP_NONE, MD_IMPLIED); // RULE18
      OP_J_ABS,
      OP_J_SHORT:     ent = mk(CTB_LEN_2, CTB_CYC_3, SP_NONE, MD_IMPLIED); // RULE18
      OP_J_IND:       ent = mk(CTB_LEN_1, CTB_CYC_5, SP_NONE, MD_INDEXED); // RULE19
      OP_J_AZ,
      OP_J_ANZ:       ent = mk(CTB_LEN_2, CTB_CYC_4, SP_NONE, MD_IMPLIED); // RULE20
      OP_CMP_A_DIR:   ent = mk(CTB_LEN_3, CTB_CYC_5, SP_CORE, MD_DIRECT); // RULE21
      OP_CMP_A_IMM:   ent = mk(CTB_LEN_3, CTB_CYC_4, SP_NONE, MD_IMMED); // RULE21
      OP_CMP_BANK_IMM: ent = mk(CTB_LEN_3, CTB_CYC_4, SP_CORE, MD_BANK); // RULE21
      OP_CMP_IND_IMM: ent = mk(CTB_LEN_3, CTB_CYC_5, SP_CORE, MD_INDIRECT); // RULE21
      OP_DEC_BANK:    ent = mk(CTB_LEN_2, CTB_CYC_4, SP_CORE, MD_BANK); // RULE22
      OP_DEC_DIR:     ent = mk(CTB_LEN_3, CTB_CYC_5, SP_CORE, MD_DIRECT); // RULE22
      default:        ent = mk(CTB_LEN_1, CTB_CYC_1, SP_NONE, MD_IMPLIED);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // pacing: a new instruction only once the last one has run out
  assign accept = op_valid && op_ready;
  assign op_ready = !busy; // RULE23

  ctb_cycle_counter #(
    .W(3)
  ) u_count (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(accept),
    .load_val(ent.cyc),
    .active(),
    .busy(busy),
    .last(instr_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // address forming; indexed sums wrap at 16 bits like the counter does
  assign idx_dp = data_pointer_in + {8'h00, acc_in}; // RULE3
  assign idx_pc = program_counter_in + {8'h00, acc_in}; // RULE3
  // low half of bit space is RAM, upper half maps onto register bytes
  assign bit_sfr = bit_addr_in >= 8'(CTB_BIT_RAM_BITS); // RULE4
  assign bit_byte = bit_sfr ? {bit_addr_in[7:3], 3'h0} :
                    BIT_RAM_BASE + {4'h0, bit_addr_in[6:3]}; // RULE4

  logic [1:0] len_d;
  logic [2:0] cyc_d;
  ctb_space_t space_d;
  ctb_mode_t mode_d;
  logic [7:0] core_addr_d;
  logic [15:0] mem_addr_d;
  logic xd_rd_d, xd_wr_d, code_rd_d, bit_sfr_d, bit_wr_d, bit_wv_d;
  logic [2:0] bit_pos_d;
  logic cy_wr_d, cy_val_d, jump_d;

  ////////////////////////////////////////////////////////////////////////
  // effects of the accepted instruction; strobes last one cycle
  always_comb begin
    len_d = instr_len_q;
    cyc_d = instr_cyc_q;
    space_d = space_q;
    mode_d = mode_q;
    core_addr_d = core_addr_q;
    mem_addr_d = mem_addr_q;
    bit_sfr_d = bit_in_sfr_q;
    bit_pos_d = bit_pos_q;
    bit_wv_d = bit_wr_val_q;
    cy_val_d = carry_val_q;
    jump_d = jump_taken_q;
    xd_rd_d = 1'b0;
    xd_wr_d = 1'b0;
    code_rd_d = 1'b0;
    bit_wr_d = 1'b0;
    cy_wr_d = 1'b0;
    if (accept) begin
      len_d = ent.len;
      cyc_d = ent.cyc;
      space_d = ent.sp;
      mode_d = ent.md;
      jump_d = 1'b0;
      // operand byte in core space by its mode
      case (ent.md)
        MD_DIRECT: core_addr_d = operand_in; // RULE1
        MD_INDIRECT: core_addr_d = ptr_reg_in; // RULE1
        MD_BANK: core_addr_d = {5'h00, reg_idx_in}; // RULE1
        MD_BIT: core_addr_d = bit_byte; // RULE4
        default: core_addr_d = core_addr_q;
      endcase
      bit_sfr_d = bit_sfr;
      bit_pos_d = bit_addr_in[CTB_BIT_POS_W-1:0];
      case (op_code)
        // external space: pointer register or data pointer only
        OP_XD_RD_IND, OP_XD_WR_IND: begin
          mem_addr_d = {8'h00, ptr_reg_in}; // RULE2
          xd_rd_d = op_code == OP_XD_RD_IND;
          xd_wr_d = op_code == OP_XD_WR_IND;
        end
        OP_XD_RD_DP, OP_XD_WR_DP: begin
          mem_addr_d = data_pointer_in; // RULE2
          xd_rd_d = op_code == OP_XD_RD_DP;
          xd_wr_d = op_code == OP_XD_WR_DP;
        end
        OP_CT_DP: begin
          mem_addr_d = idx_dp; // RULE3
          code_rd_d = 1'b1;
        end
        OP_CT_PROG: begin
          mem_addr_d = idx_pc; // RULE3
          code_rd_d = 1'b1;
        end
        OP_J_IND: begin
          mem_addr_d = idx_dp; // RULE19
          jump_d = 1'b1;
        end
        OP_CY_CLR, OP_CY_SET, OP_CY_INV: begin
          cy_wr_d = 1'b1; // RULE15
          cy_val_d = (op_code == OP_CY_SET) ||
                     ((op_code == OP_CY_INV) && !carry_in);
        end
        OP_BIT_CLR, OP_BIT_SET, OP_BIT_INV, OP_CY_ST: begin
          bit_wr_d = 1'b1; // RULE15
          case (op_code)
            OP_BIT_CLR: bit_wv_d = 1'b0;
            OP_BIT_SET: bit_wv_d = 1'b1;
            OP_BIT_INV: bit_wv_d = !bit_val_in;
            default: bit_wv_d = carry_in;
          endcase
        end
        OP_CY_AND: begin
          cy_wr_d = 1'b1;
          cy_val_d = carry_in && bit_val_in; // RULE16
        end
        OP_CY_ANDN: begin
          cy_wr_d = 1'b1;
          cy_val_d = carry_in && !bit_val_in; // RULE16
        end
        OP_CY_OR: begin
          cy_wr_d = 1'b1;
          cy_val_d = carry_in || bit_val_in; // RULE16
        end
        OP_CY_ORN: begin
          cy_wr_d = 1'b1;
          cy_val_d = carry_in || !bit_val_in; // RULE16
        end
        OP_CY_LD: begin
          cy_wr_d = 1'b1;
          cy_val_d = bit_val_in; // RULE16
        end
        OP_J_CY: jump_d = carry_in; // RULE17
        OP_J_NCY: jump_d = !carry_in; // RULE17
        OP_J_BIT: jump_d = bit_val_in; // RULE17
        OP_J_NBIT: jump_d = !bit_val_in; // RULE17
        OP_J_BITCLR: begin
          // clear only when found set, so a clear bit is not rewritten
          jump_d = bit_val_in; // RULE17
          bit_wr_d = bit_val_in; // RULE17
          bit_wv_d = 1'b0;
        end
        OP_J_AZ: jump_d = acc_in == 8'h00; // RULE20
        OP_J_ANZ: jump_d = acc_in != 8'h00; // RULE20
        OP_CMP_A_DIR, OP_CMP_A_IMM, OP_CMP_BANK_IMM, OP_CMP_IND_IMM:
          jump_d = cmp_lhs_in != cmp_rhs_in; // RULE21
        OP_DEC_BANK, OP_DEC_DIR:
          jump_d = dec_val_in != 8'h01; // RULE22
        OP_CALL_ABS, OP_CALL_LONG, OP_SUB_EXIT, OP_INT_EXIT,
        OP_J_ABS, OP_J_LONG, OP_J_SHORT:
          jump_d = 1'b1; // RULE18
        default: jump_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      instr_len_q <= 2'h0;
      instr_cyc_q <= 3'h0;
      space_q <= SP_NONE;
      mode_q <= MD_IMPLIED;
      core_addr_q <= 8'h00;
      mem_addr_q <= 16'h0000;
      xd_rd_q <= 1'b0;
      xd_wr_q <= 1'b0;
      code_rd_q <= 1'b0;
      bit_in_sfr_q <= 1'b0;
      bit_pos_q <= 3'h0;
      bit_wr_q <= 1'b0;
      bit_wr_val_q <= 1'b0;
      carry_wr_q <= 1'b0;
      carry_val_q <= 1'b0;
      jump_taken_q <= 1'b0;
    end else begin
      instr_len_q <= len_d;
      instr_cyc_q <= cyc_d;
      space_q <= space_d;
      mode_q <= mode_d;
      core_addr_q <= core_addr_d;
      mem_addr_q <= mem_addr_d;
      xd_rd_q <= xd_rd_d;
      xd_wr_q <= xd_wr_d;
      code_rd_q <= code_rd_d;
      bit_in_sfr_q <= bit_sfr_d;
      bit_pos_q <= bit_pos_d;
      bit_wr_q <= bit_wr_d;
      bit_wr_val_q <= bit_wv_d;
      carry_wr_q <= cy_wr_d;
      carry_val_q <= cy_val_d;
      jump_taken_q <= jump_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_XD_IND: assert property ((xd_rd_q || xd_wr_q) |-> // RULE2
    (mode_q == MD_INDIRECT && space_q == SP_XDATA))
    else $error("external access not indirect");
  AST_CODE_IDX: assert property (accept && op_code == OP_CT_DP |=> // RULE3
    code_rd_q && mem_addr_q == $past(idx_dp) && !xd_wr_q)
    else $error("code read address wrong");
  AST_BIT_RAM: assert property (accept && ent.md == MD_BIT && // RULE4
    bit_addr_in < 8'h80 |=> !bit_in_sfr_q && space_q == SP_BIT)
    else $error("low bit address not in RAM");
  AST_A_IND: assert property (accept && op_code == OP_MV_A_IND |=> // RULE5
    instr_len_q == 2'h1 && instr_cyc_q == 3'h2 ##1 op_ready)
    else $error("indirect load timing wrong");
  AST_BANK_DIR: assert property (accept && op_code == OP_MV_BANK_DIR // RULE6
    |=> !op_ready ##1 !op_ready ##1 op_ready)
    else $error("bank load from direct not 3 cycles");
  AST_DP_LOAD: assert property (accept && op_code == OP_MV_DP_IMM |=> // RULE9
    instr_len_q == 2'h3 ##2 instr_done)
    else $error("data pointer load not 3 cycles");
  AST_XD_WR8: assert property (accept && op_code == OP_XD_WR_IND |=> // RULE12
    !op_ready [*4] ##1 op_ready)
    else $error("8-bit external write not 5 cycles");
  AST_BITCLR: assert property (accept && op_code == OP_J_BITCLR && // RULE17
    bit_val_in |=> bit_wr_q && !bit_wr_val_q && jump_taken_q)
    else $error("test-clear jump did not clear");
  AST_IND_JUMP: assert property (accept && op_code == OP_J_IND |=> // RULE19
    jump_taken_q && !op_ready [*4] ##1 instr_done)
    else $error("indirect jump timing wrong");
  AST_CMP_LEN: assert property (accept && op_code inside {OP_CMP_A_DIR, // RULE21
    OP_CMP_A_IMM, OP_CMP_BANK_IMM, OP_CMP_IND_IMM} |=> instr_len_q == 2'h3)
    else $error("compare jump length wrong");
  AST_PACE: assert property (accept && ent.cyc == 3'h4 |=> // RULE23
    !op_ready [*3] ##1 (op_ready && instr_done))
    else $error("four-cycle instruction released early");

  COV_B2B: cover property (accept ##1 accept ##1 accept);
  COV_XD_WR: cover property (accept && op_code == OP_XD_WR_DP);
  COV_BITCLR: cover property (accept && op_code == OP_J_BITCLR && bit_val_in);
  COV_SFR_BIT: cover property (accept && ent.md == MD_BIT && bit_sfr);

endmodule
`default_nettype wire

// ===== test/ctb_bit_mem.sv
// bit space model standing in for core ram bits and register bits
`default_nettype none
module ctb_bit_mem (
  input wire logic mclk,
  input wire logic [7:0] bit_addr_in,
  input wire logic bit_wr_q,
  input wire logic bit_in_sfr_q,
  input wire logic [7:0] core_addr_q,
  input wire logic [2:0] bit_pos_q,
  input wire logic bit_wr_val_q,
  output logic bit_val
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [255:0] mem = {8{32'h5a3c_96e1}};
  logic [7:0] widx;
  ////////////////////////////////////////////////////////////////////
  // low half holds the 128 ram bits, high half the register bits
  assign bit_val = mem[bit_addr_in];
  // ram byte assumes base 0, so the byte number is the bit group
  assign widx = bit_in_sfr_q ? {core_addr_q[7:3], bit_pos_q} :
                {1'b0, core_addr_q[3:0], bit_pos_q};
  // one-cycle strobe, taken at its closing edge
  always @(posedge mclk) begin
    if (bit_wr_q === 1'b1) mem[widx] <= bit_wr_val_q;
  end
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the transfer, bit and branch timing decoder
`default_nettype none
module tb_top
  import ctb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, op_valid, op_ready, carry_in, bit_val_in, instr_done;
  ctb_op_t op_code;
  logic [7:0] operand_in, ptr_reg_in, acc_in, bit_addr_in;
  logic [7:0] cmp_lhs_in, cmp_rhs_in, dec_val_in, core_addr_q;
  logic [2:0] reg_idx_in, instr_cyc_q, bit_pos_q;
  logic [15:0] data_pointer_in, program_counter_in, mem_addr_q;
  logic [1:0] instr_len_q;
  ctb_space_t space_q;
  ctb_mode_t mode_q;
  logic xd_rd_q, xd_wr_q, code_rd_q, bit_in_sfr_q, bit_wr_q, bit_wr_val_q;
  logic carry_wr_q, carry_val_q, jump_taken_q;
  int n_mismatch = 0, n_tests = 0, seed = 92264, i;

  ctb_decoder dut (.mclk(mclk), .rst_n(rst_n), .op_valid(op_valid),
    .op_ready(op_ready), .op_code(op_code), .operand_in(operand_in),
    .reg_idx_in(reg_idx_in), .ptr_reg_in(ptr_reg_in), .acc_in(acc_in),
    .data_pointer_in(data_pointer_in), .carry_in(carry_in),
    .program_counter_in(program_counter_in), .bit_addr_in(bit_addr_in),
    .bit_val_in(bit_val_in), .cmp_lhs_in(cmp_lhs_in),
    .cmp_rhs_in(cmp_rhs_in), .dec_val_in(dec_val_in),
    .instr_done(instr_done), .instr_len_q(instr_len_q),
    .instr_cyc_q(instr_cyc_q), .space_q(space_q), .mode_q(mode_q),
    .core_addr_q(core_addr_q), .mem_addr_q(mem_addr_q), .xd_rd_q(xd_rd_q),
    .xd_wr_q(xd_wr_q), .code_rd_q(code_rd_q), .bit_in_sfr_q(bit_in_sfr_q),
    .bit_pos_q(bit_pos_q), .bit_wr_q(bit_wr_q),
    .bit_wr_val_q(bit_wr_val_q), .carry_wr_q(carry_wr_q),
    .carry_val_q(carry_val_q), .jump_taken_q(jump_taken_q));
  ctb_bit_mem bmem (.mclk(mclk), .bit_addr_in(bit_addr_in),
    .bit_wr_q(bit_wr_q), .bit_in_sfr_q(bit_in_sfr_q),
    .core_addr_q(core_addr_q), .bit_pos_q(bit_pos_q),
    .bit_wr_val_q(bit_wr_val_q), .bit_val(bit_val_in));

  ////////////////////////////////////////////////////////////////////
  // comparison and closing report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // reference table of {bytes, cycles} per instruction class
  function automatic logic [4:0] lc(input ctb_op_t o);
    case (o)
      OP_MV_A_BANK, OP_MV_BANK_A, OP_CY_CLR, OP_CY_SET, OP_CY_INV,
      OP_NOP: lc = 5'h09;
      OP_MV_A_DIR, OP_MV_A_IMM, OP_MV_BANK_IMM, OP_MV_DIR_A, OP_MV_DIR_BANK,
      OP_MV_IND_IMM, OP_POP_DIR, OP_CY_AND, OP_CY_ANDN, OP_CY_OR,
      OP_CY_ORN, OP_CY_LD: lc = 5'h12;
      OP_MV_A_IND, OP_MV_IND_A, OP_SWP_BANK: lc = 5'h0a;
      OP_MV_BANK_DIR, OP_MV_DIR_IND, OP_MV_IND_DIR, OP_PUSH_DIR, OP_SWP_DIR,
      OP_BIT_CLR, OP_BIT_SET, OP_BIT_INV, OP_CY_ST, OP_J_CY, OP_J_NCY,
      OP_J_ABS, OP_J_SHORT: lc = 5'h13;
      OP_MV_DIR_DIR, OP_MV_DIR_IMM, OP_MV_DP_IMM: lc = 5'h1b;
      OP_CT_DP, OP_XD_WR_IND, OP_J_IND: lc = 5'h0d;
      OP_CT_PROG, OP_XD_RD_IND, OP_XD_WR_DP, OP_SUB_EXIT,
      OP_INT_EXIT: lc = 5'h0c;
      OP_XD_RD_DP, OP_SWP_IND, OP_SWPD_IND: lc = 5'h0b;
      OP_J_BIT, OP_J_NBIT, OP_J_BITCLR, OP_CMP_A_DIR, OP_CMP_IND_IMM,
      OP_DEC_DIR: lc = 5'h1d;
      OP_CALL_ABS, OP_J_AZ, OP_J_ANZ, OP_DEC_BANK: lc = 5'h14;
      OP_CALL_LONG, OP_J_LONG, OP_CMP_A_IMM,
      OP_CMP_BANK_IMM: lc = 5'h1c;
      default: lc = 5'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // offer one instruction and check its results
  task automatic run(input ctb_op_t o);
    int k, c, n;
    logic [31:0] r, q, p;
    logic [4:0] e;
    logic [2:0] st;
    logic [1:0] jt, bw, cw;
    logic [15:0] ma;
    logic b;
    r = $random(seed);
    q = $random(seed);
    p = $random(seed);
    op_code <= o;
    acc_in <= r[8] ? r[7:0] : 8'h00;
    ptr_reg_in <= r[15:8];
    bit_addr_in <= r[23:16] & 8'hc9;
    operand_in <= r[31:24];
    data_pointer_in <= q[15:0];
    reg_idx_in <= q[18:16];
    carry_in <= q[19];
    dec_val_in <= {6'h00, q[21:20]};
    program_counter_in <= p[15:0];
    cmp_lhs_in <= p[23:16];
    cmp_rhs_in <= p[31] ? p[23:16] : p[31:24];
    op_valid <= 1'b1;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (op_ready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk(16'h0000, 16'h0001, "no ready");
      wrap_up();
    end
    e = lc(o);
    n = e[2:0];
    b = bit_val_in;
    st = 3'h0;
    ma = 16'h0000;
    jt = {1'b1, o inside {[OP_CALL_ABS:OP_J_IND]}};
    bw = 2'h0;
    cw = 2'h0;
    case (o)
      OP_XD_RD_IND: begin st = 3'h4; ma = {8'h00, ptr_reg_in}; end
      OP_XD_RD_DP: begin st = 3'h4; ma = data_pointer_in; end
      OP_XD_WR_IND: begin st = 3'h2; ma = {8'h00, ptr_reg_in}; end
      OP_XD_WR_DP: begin st = 3'h2; ma = data_pointer_in; end
      OP_CT_DP: begin st = 3'h1; ma = data_pointer_in + acc_in; end
      OP_CT_PROG: begin st = 3'h1; ma = program_counter_in + acc_in; end
      OP_J_IND: ma = data_pointer_in + acc_in;
      OP_CY_CLR: cw = 2'h2;
      OP_CY_SET: cw = 2'h3;
      OP_CY_INV: cw = {1'b1, ~carry_in};
      OP_CY_AND: cw = {1'b1, carry_in & b};
      OP_CY_ANDN: cw = {1'b1, carry_in & ~b};
      OP_CY_OR: cw = {1'b1, carry_in | b};
      OP_CY_ORN: cw = {1'b1, carry_in | ~b};
      OP_CY_LD: cw = {1'b1, b};
      OP_BIT_CLR: bw = 2'h2;
      OP_BIT_SET: bw = 2'h3;
      OP_BIT_INV: bw = {1'b1, ~b};
      OP_CY_ST: bw = {1'b1, carry_in};
      OP_J_CY: jt = {1'b1, carry_in};
      OP_J_NCY: jt = {1'b1, ~carry_in};
      OP_J_BIT: jt = {1'b1, b};
      OP_J_NBIT: jt = {1'b1, ~b};
      OP_J_BITCLR: begin jt = {1'b1, b}; bw = {b, 1'b0}; end
      OP_J_AZ: jt = {1'b1, acc_in == 8'h00};
      OP_J_ANZ: jt = {1'b1, acc_in != 8'h00};
      OP_CMP_A_DIR, OP_CMP_A_IMM, OP_CMP_BANK_IMM,
      OP_CMP_IND_IMM: jt = {1'b1, cmp_lhs_in != cmp_rhs_in};
      OP_DEC_BANK, OP_DEC_DIR: jt = {1'b1, dec_val_in != 8'h01};
    endcase
    @(posedge mclk);
    if (n == 1) op_valid <= 1'b0;
    // multi-cycle ones hold valid over edge 1, refused while busy; 1-cycle ones drop it at the accept edge
    for (c = 1; c <= n; c++) begin
      @(negedge mclk);
      chk(instr_done, c == n, "done");
      chk(op_ready, c == n, "ready");
      if (c == 2) chk({xd_rd_q, xd_wr_q, code_rd_q, bit_wr_q, carry_wr_q},
                      16'h0000, "pulse");
      if (c == 1) begin
        chk({instr_len_q, instr_cyc_q}, e, "len cyc");
        chk({xd_rd_q, xd_wr_q, code_rd_q}, st, "strobe");
        if (st != 3'h0 || o == OP_J_IND)
          chk(mem_addr_q, ma, "addr");
        if (st[2] | st[1]) chk({space_q, mode_q},
                               {SP_XDATA, MD_INDIRECT}, "xdata");
        if (st[0]) chk({space_q, mode_q},
                       {SP_CODE, MD_INDEXED}, "code");
        if (o <= OP_MV_IND_IMM) chk(space_q, SP_CORE, "core");
        chk(jump_taken_q, jt[0], "jump");
        chk(carry_wr_q, cw[1], "cy wr");
        if (cw[1]) chk(carry_val_q, cw[0], "cy val");
        chk(bit_wr_q, bw[1], "bit wr");
        if (bw[1]) chk(bit_wr_val_q, bw[0], "bit val");
        if (o inside {[OP_BIT_CLR:OP_CY_ST], [OP_J_BIT:OP_J_BITCLR]})
          chk({bit_in_sfr_q, bit_pos_q, core_addr_q},
              {bit_addr_in[7], bit_addr_in[2:0], bit_addr_in[7] ?
               {bit_addr_in[7:3], 3'h0} : {4'h0, bit_addr_in[6:3]}},
              "bit loc");
      end
      @(posedge mclk);
      if (c == 1 && n > 1) op_valid <= 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  // clock, reset and the main sequence
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    rst_n = 1'b0;
    op_valid = 1'b0;
    op_code = OP_NOP;
    {operand_in, ptr_reg_in, acc_in, bit_addr_in} = 32'h0000_0000;
    {cmp_lhs_in, cmp_rhs_in, dec_val_in, reg_idx_in, carry_in} = 28'h000_0000;
    {data_pointer_in, program_counter_in} = 32'h0000_0000;
    repeat (10) @(posedge mclk);
    chk({op_ready, instr_done, space_q}, {2'b10, SP_NONE}, "reset");
    rst_n <= 1'b1;
    // every class once in order, then a random mix
    for (i = 0; i <= int'(OP_NOP); i++) run(ctb_op_t'(i));
    for (i = 0; i < 300; i++) run(ctb_op_t'($unsigned($random(seed)) % 62));
    wrap_up();
  end
endmodule
`default_nettype wire
